//--- rtl/dta_map.svh
// constants of the dma to pcie tlp adapter: channels, tlp field positions, codes
// assumes a 64-bit tlp word with a two-word header, word 0 carrying format and length
`ifndef DTA_MAP_SVH
`define DTA_MAP_SVH
`define DTA_CH_WR 3'h0
`define DTA_CH_RD 3'h1
`define DTA_FT_MWR 8'h40
`define DTA_FT_MRD 8'h00
`define DTA_FT_CPLD 8'h4a
`define DTA_H0_FT 63:56
`define DTA_H0_LEN 41:32
`define DTA_H0_TAG 15:8
`define DTA_H0_BE 7:0
`define DTA_H0_DATA 62
`define DTA_H1_TAG 31:24
`define DTA_BE_ALL 8'hff
`define DTA_E_ST 65
`define DTA_E_END 64
`define DTA_DW_SH 2
`define DTA_WD_SH 3
`define DTA_PD_SH 2
`define DTA_PD_RND 10'h003
`define DTA_WORD_BYTES 9'h008
`define DTA_ONE_HDR 8'h01
`endif

//--- rtl/dta_pkg.sv
// state types of the dma to pcie tlp adapter
// assumes nothing beyond a systemverilog compiler
package dta_pkg;
  typedef enum logic [1:0] {DTA_B_IDLE = 2'b00, DTA_B_HDR1 = 2'b01, DTA_B_DATA = 2'b11} dta_bus_t;
  typedef enum logic [1:0] {DTA_C_IDLE = 2'b00, DTA_C_REQ = 2'b01, DTA_C_SEND = 2'b11} dta_ctl_t;
  typedef enum logic [1:0] {
    DTA_R_H0 = 2'b00, DTA_R_H1 = 2'b01, DTA_R_DATA = 2'b11, DTA_R_DROP = 2'b10
  } dta_rx_t;
endpackage

//--- rtl/dta_stream_if.sv
// valid/ready word stream between the adapter's own modules
// assumes both ends on clk_sys
`timescale 1ns/1ps
interface dta_stream_if #(parameter int W = 66) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

//--- rtl/dta_skid2.sv
// two-entry buffer: an output register plus one skid register
// assumes an asynchronous active-low reset already released on clk_sys
`timescale 1ns/1ps
module dta_skid2 #(
  parameter int W = 66
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // streams
  dta_stream_if.snk i_s,
  dta_stream_if.src o_s
);
  logic out_v_r;
  logic skid_v_r;
  logic [W-1:0] out_d_r;
  logic [W-1:0] skid_d_r;

  // ready is a flop so the source never sees a combinational path from the sink
  assign i_s.ready = ~skid_v_r;
  assign o_s.valid = out_v_r;
  assign o_s.data = out_d_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      out_d_r <= '0;
      skid_d_r <= '0;
    end else if (o_s.ready || !out_v_r) begin
      if (skid_v_r) begin
        out_d_r <= skid_d_r;
        out_v_r <= 1'b1;
        skid_v_r <= 1'b0;
      end else begin
        out_d_r <= i_s.data;
        out_v_r <= i_s.valid;
      end
    end else if (i_s.valid && !skid_v_r) begin
      skid_d_r <= i_s.data;
      skid_v_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_SKID_HOLD: assert property (out_v_r && !o_s.ready |=> out_v_r && $stable(out_d_r))
    else $error("buffered tlp word changed while stalled");
endmodule

//--- rtl/dta_credit_checker.sv
// compares the credit cost of the tlp at the fifo head with the core's credits
// assumes the credit counts are steady on clk_sys and hdr is header word 0
`timescale 1ns/1ps
`include "dta_map.svh"
module dta_credit_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // head of the transmit fifo
  input wire logic [63:0] hdr,
  input wire logic hdr_valid,
  // credits the core has available
  input wire logic [7:0] ca_ph,
  input wire logic [11:0] ca_pd,
  input wire logic [7:0] ca_nph,
  // verdict
  output logic ok
);
  logic [9:0] pd_cost;
  logic posted;
  logic ok_r;

  assign posted = hdr[`DTA_H0_DATA];
  assign pd_cost = 10'((hdr[`DTA_H0_LEN] + `DTA_PD_RND) >> `DTA_PD_SH);
  assign ok = ok_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ok_r <= 1'b0;
    end else if (posted) begin
      ok_r <= hdr_valid && (ca_ph != '0) && (ca_pd >= 12'(pd_cost));
    end else begin
      ok_r <= hdr_valid && (ca_nph != '0);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_CC_NOPH: assert property (hdr_valid && posted && ca_ph == '0 |=> !ok_r)
    else $error("credit ok given with no posted header credit");
endmodule

//--- rtl/dta_top.sv
// dma to pcie tlp adapter: bus slave to the dma engine, tx tlp path, rx completion path
// assumes the dma master and the pcie core transaction ports run on clk_sys
`timescale 1ns/1ps
`include "dta_map.svh"
module dta_top #(
  parameter int NCH = 5,
  parameter int TXD = 32,
  parameter int RXD = 16,
  parameter int MAXB = 128
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus slave toward the dma master
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [2:0] wb_chan,
  input wire logic [31:0] wb_adr,
  input wire logic [7:0] wb_blen,
  input wire logic [63:0] wb_wdata,
  output logic wb_ack,
  output logic wb_rty,
  output logic [63:0] wb_rdata,
  output logic [NCH-1:0] dma_req,
  // transmit toward the pcie core
  output logic tx_req,
  input wire logic tx_rdy,
  output logic tx_val,
  output logic tx_st,
  output logic tx_end,
  output logic [63:0] tx_data,
  input wire logic tx_accept,
  input wire logic [7:0] tx_ca_ph,
  input wire logic [11:0] tx_ca_pd,
  input wire logic [7:0] tx_ca_nph,
  // receive from the pcie core
  input wire logic rx_val,
  input wire logic rx_st,
  input wire logic rx_end,
  input wire logic [63:0] rx_data,
  output logic rx_cr_cplh,
  output logic rx_cr_cpld
);
  localparam int TPW = $clog2(TXD);
  localparam int RPW = $clog2(RXD);

  if (TXD < MAXB / 8 + 2 || RXD < MAXB / 8 || (TXD & (TXD - 1)) != 0 ||
      (RXD & (RXD - 1)) != 0 || NCH < 2) begin : g_bad
    $error("dta_top: fifo depths or channel count cannot serve the burst size");
  end

  logic [1:0] rst_q;
  logic rst_s_n;
  dta_pkg::dta_bus_t bs_r;
  dta_pkg::dta_ctl_t cs_r;
  dta_pkg::dta_rx_t rs_r;
  logic [31:0] adr_r;
  logic [7:0] beats_r;
  logic [7:0] exp_r;
  logic [7:0] tag_r;
  logic rd_r;
  logic rd_out_r;
  logic rdreq_r;
  logic wb_ack_r;
  logic wb_rty_r;
  logic [63:0] wb_rdata_r;
  logic tx_req_r;
  logic rx_cr_cplh_r;
  logic rx_cr_cpld_r;
  logic [65:0] tx_mem [TXD];
  logic [TPW-1:0] tx_wp;
  logic [TPW-1:0] tx_rp;
  logic [TPW:0] tx_cnt;
  logic [TPW:0] tlp_cnt;
  logic [63:0] rx_mem [RXD];
  logic [RPW-1:0] rx_wp;
  logic [RPW-1:0] rx_rp;
  logic [RPW:0] rx_cnt;
  logic [8:0] rx_bytes;
  logic bus_go;
  logic is_wr;
  logic is_rd;
  logic tx_space;
  logic tx_push;
  logic [65:0] tx_win;
  logic [63:0] h0;
  logic tx_pop;
  logic [65:0] tx_head;
  logic rd_issue;
  logic rd_pop;
  logic rx_push;
  logic rx_done;
  logic cc_ok;
  logic cc_valid;

  dta_stream_if #(.W(66)) sk_in ();
  dta_stream_if #(.W(66)) sk_out ();

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= '0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_q[1];

  // outputs straight from flops
  assign wb_ack = wb_ack_r;
  assign wb_rty = wb_rty_r;
  assign wb_rdata = wb_rdata_r;
  assign tx_req = tx_req_r;
  assign rx_cr_cplh = rx_cr_cplh_r;
  assign rx_cr_cpld = rx_cr_cpld_r;
  assign tx_val = sk_out.valid;
  assign tx_st = sk_out.data[`DTA_E_ST];
  assign tx_end = sk_out.data[`DTA_E_END];
  assign tx_data = sk_out.data[63:0];
  assign sk_out.ready = tx_accept;

  for (genvar g = 0; g < NCH; g++) begin : g_req
    if (g == `DTA_CH_RD) begin : g_rd
      assign dma_req[g] = rdreq_r;
    end else begin : g_idle
      assign dma_req[g] = 1'b0;
    end
  end

  // bus side decode
  assign bus_go = wb_cyc && wb_stb && !wb_ack_r && !wb_rty_r;
  assign is_wr = bus_go && wb_we && (wb_chan == `DTA_CH_WR);
  assign is_rd = bus_go && !wb_we && (wb_chan == `DTA_CH_RD);
  assign tx_space = tx_cnt < (TPW + 1)'(TXD);
  assign rd_issue = (bs_r == dta_pkg::DTA_B_IDLE) && is_rd && !rd_out_r && tx_space;
  assign rd_pop = (bs_r == dta_pkg::DTA_B_DATA) && rd_r && wb_cyc && wb_stb && !wb_we &&
                  !wb_ack_r && (rx_cnt != '0);

  // one writer into the shared transmit fifo
  always_comb begin
    tx_push = 1'b0;
    tx_win = '0;
    h0 = '0;
    h0[`DTA_H0_LEN] = 10'(wb_blen >> `DTA_DW_SH);
    h0[`DTA_H0_BE] = `DTA_BE_ALL;
    unique case (bs_r)
      dta_pkg::DTA_B_IDLE: begin
        if (is_wr && tx_space) begin
          h0[`DTA_H0_FT] = `DTA_FT_MWR;
          tx_push = 1'b1;
          tx_win = {1'b1, 1'b0, h0};
        end else if (rd_issue) begin
          h0[`DTA_H0_FT] = `DTA_FT_MRD;
          h0[`DTA_H0_TAG] = tag_r;
          tx_push = 1'b1;
          tx_win = {1'b1, 1'b0, h0};
        end
      end
      dta_pkg::DTA_B_HDR1: begin
        tx_push = tx_space;
        tx_win = {1'b0, rd_r, 64'(adr_r)};
      end
      dta_pkg::DTA_B_DATA: begin
        if (!rd_r && wb_cyc && wb_stb && wb_we && !wb_ack_r && tx_space) begin
          tx_push = 1'b1;
          tx_win = {1'b0, beats_r == `DTA_ONE_HDR, wb_wdata};
        end
      end
      default: begin
      end
    endcase
  end

  // bus slave sequencing
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      bs_r <= dta_pkg::DTA_B_IDLE;
      adr_r <= '0;
      beats_r <= '0;
      exp_r <= '0;
      rd_r <= 1'b0;
      rd_out_r <= 1'b0;
      tag_r <= '0;
      wb_ack_r <= 1'b0;
      wb_rty_r <= 1'b0;
      wb_rdata_r <= '0;
    end else begin
      wb_ack_r <= 1'b0;
      wb_rty_r <= 1'b0;
      unique case (bs_r)
        dta_pkg::DTA_B_IDLE: begin
          if (is_wr && tx_space) begin
            adr_r <= wb_adr;
            beats_r <= 8'(wb_blen >> `DTA_WD_SH);
            rd_r <= 1'b0;
            bs_r <= dta_pkg::DTA_B_HDR1;
          end else if (is_rd) begin
            if (!rd_out_r) begin
              if (tx_space) begin
                wb_rty_r <= 1'b1;
                adr_r <= wb_adr;
                exp_r <= wb_blen;
                rd_r <= 1'b1;
                rd_out_r <= 1'b1;
                bs_r <= dta_pkg::DTA_B_HDR1;
              end
            end else if (rdreq_r) begin
              rd_r <= 1'b1;
              bs_r <= dta_pkg::DTA_B_DATA;
            end else begin
              wb_rty_r <= 1'b1;
            end
          end
        end
        dta_pkg::DTA_B_HDR1: begin
          if (tx_space) begin
            bs_r <= rd_r ? dta_pkg::DTA_B_IDLE : dta_pkg::DTA_B_DATA;
          end
        end
        dta_pkg::DTA_B_DATA: begin
          if (tx_push) begin
            wb_ack_r <= 1'b1;
            beats_r <= beats_r - `DTA_ONE_HDR;
            if (beats_r == `DTA_ONE_HDR) begin
              bs_r <= dta_pkg::DTA_B_IDLE;
            end
          end else if (rd_pop) begin
            wb_ack_r <= 1'b1;
            wb_rdata_r <= rx_mem[rx_rp];
            if (rx_cnt == (RPW + 1)'(1)) begin
              bs_r <= dta_pkg::DTA_B_IDLE;
              rd_out_r <= 1'b0;
              tag_r <= tag_r + `DTA_ONE_HDR;
            end
          end
        end
        default: bs_r <= dta_pkg::DTA_B_IDLE;
      endcase
    end
  end

  // transmit fifo storage; only whole tlps are offered to the core
  assign tx_head = tx_mem[tx_rp];
  assign tx_pop = (cs_r == dta_pkg::DTA_C_SEND) && (tx_cnt != '0) && sk_in.ready;
  assign sk_in.valid = tx_pop;
  assign sk_in.data = tx_head;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      tlp_cnt <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= tx_win;
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + 1'b1;
      end
      tx_cnt <= tx_cnt + (TPW + 1)'(tx_push) - (TPW + 1)'(tx_pop);
      tlp_cnt <= tlp_cnt + (TPW + 1)'(tx_push && tx_win[`DTA_E_END]) -
                 (TPW + 1)'(tx_pop && tx_head[`DTA_E_END]);
    end
  end

  // credits are judged only while idle, so the verdict always describes a header word
  assign cc_valid = (cs_r == dta_pkg::DTA_C_IDLE) && (tlp_cnt != '0);

  dta_credit_checker u_cc (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .hdr(tx_head[63:0]),
    .hdr_valid(cc_valid),
    .ca_ph(tx_ca_ph),
    .ca_pd(tx_ca_pd),
    .ca_nph(tx_ca_nph),
    .ok(cc_ok)
  );

  // transmit control: credits, request, grant, then the words
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cs_r <= dta_pkg::DTA_C_IDLE;
      tx_req_r <= 1'b0;
    end else begin
      unique case (cs_r)
        dta_pkg::DTA_C_IDLE: begin
          if (cc_valid && cc_ok) begin
            tx_req_r <= 1'b1;
            cs_r <= dta_pkg::DTA_C_REQ;
          end
        end
        dta_pkg::DTA_C_REQ: begin
          if (tx_rdy) begin
            tx_req_r <= 1'b0;
            cs_r <= dta_pkg::DTA_C_SEND;
          end
        end
        dta_pkg::DTA_C_SEND: begin
          if (tx_pop && tx_head[`DTA_E_END]) begin
            cs_r <= dta_pkg::DTA_C_IDLE;
          end
        end
        default: cs_r <= dta_pkg::DTA_C_IDLE;
      endcase
    end
  end

  dta_skid2 #(.W(66)) u_skid (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .i_s(sk_in),
    .o_s(sk_out)
  );

  // completion parsing; the core cannot be stalled, so an overfull buffer drops words
  assign rx_push = rx_val && (rs_r == dta_pkg::DTA_R_DATA) && (rx_cnt < (RPW + 1)'(RXD));

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rs_r <= dta_pkg::DTA_R_H0;
    end else if (rx_val) begin
      unique case (rs_r)
        dta_pkg::DTA_R_H0: begin
          if (rx_st && !rx_end) begin
            rs_r <= (rx_data[`DTA_H0_FT] == `DTA_FT_CPLD) ? dta_pkg::DTA_R_H1 :
                    dta_pkg::DTA_R_DROP;
          end
        end
        dta_pkg::DTA_R_H1: begin
          if (rx_end) begin
            rs_r <= dta_pkg::DTA_R_H0;
          end else if (rd_out_r && rx_data[`DTA_H1_TAG] == tag_r) begin
            rs_r <= dta_pkg::DTA_R_DATA;
          end else begin
            rs_r <= dta_pkg::DTA_R_DROP;
          end
        end
        dta_pkg::DTA_R_DATA, dta_pkg::DTA_R_DROP: begin
          if (rx_end) begin
            rs_r <= dta_pkg::DTA_R_H0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_bytes <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= rx_data;
        rx_wp <= rx_wp + 1'b1;
      end
      if (rd_pop) begin
        rx_rp <= rx_rp + 1'b1;
      end
      rx_cnt <= rx_cnt + (RPW + 1)'(rx_push) - (RPW + 1)'(rd_pop);
      if (rd_issue) begin
        rx_bytes <= '0;
      end else if (rx_push) begin
        rx_bytes <= rx_bytes + `DTA_WORD_BYTES;
      end
    end
  end

  // request to the engine; arrival is masked during read-out, so the clear from the last read-out wins
  assign rx_done = rd_out_r && (rx_bytes >= {1'b0, exp_r}) &&
                   !(bs_r == dta_pkg::DTA_B_DATA && rd_r);

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rdreq_r <= 1'b0;
      rx_cr_cplh_r <= 1'b0;
      rx_cr_cpld_r <= 1'b0;
    end else begin
      if (rx_done) begin
        rdreq_r <= 1'b1;
      end else if (rd_pop && rx_cnt == (RPW + 1)'(1)) begin
        rdreq_r <= 1'b0;
      end
      rx_cr_cpld_r <= rd_pop;
      rx_cr_cplh_r <= rd_pop && (rx_cnt == (RPW + 1)'(1));
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_s_n);

  // a full fifo may hold the second header back; the slave then waits in its header state
  sequence s_mrd_hdrs;
    tx_push && tx_win[`DTA_E_ST] && tx_win[`DTA_H0_FT] == `DTA_FT_MRD ##1
    bs_r == dta_pkg::DTA_B_HDR1 && (tx_space ? tx_push && tx_win[`DTA_E_END] : !tx_push);
  endsequence

  sequence s_fresh_read;
    bs_r == dta_pkg::DTA_B_IDLE && is_rd && !rd_out_r && tx_space;
  endsequence

  AST_RD_RETRY: assert property (s_fresh_read |=> wb_rty && !wb_ack)
    else $error("fresh channel 1 read not retried");
  AST_RD_TLP: assert property (s_fresh_read |-> s_mrd_hdrs)
    else $error("retried read did not queue a two-word read tlp");
  AST_REQ_CRED: assert property ($rose(tx_req) |-> $past(cc_ok) && $past(cc_valid) &&
                                 ($past(tx_head[`DTA_H0_DATA], 2) ? $past(tx_ca_ph, 2) != '0 :
                                  $past(tx_ca_nph, 2) != '0))
    else $error("transmit request raised without credit verdict");
  AST_SEND_GRANT: assert property ($rose(cs_r == dta_pkg::DTA_C_SEND) |->
                                   $past(tx_req) && $past(tx_rdy))
    else $error("tlp words sent before request was granted");
  AST_TAG_DROP: assert property (rs_r == dta_pkg::DTA_R_H1 && rx_val && !rx_end &&
                                 rx_data[`DTA_H1_TAG] != tag_r |=>
                                 rs_r == dta_pkg::DTA_R_DROP)
    else $error("completion with foreign tag was kept");
  AST_REQ_FULL: assert property ($rose(rdreq_r) |-> $past(rx_bytes) >= {1'b0, exp_r})
    else $error("dma request before all completion bytes arrived");
  AST_CRED_REL: assert property (rd_pop |=> rx_cr_cpld ##1 !rx_cr_cpld || rd_pop)
    else $error("completion credit not released on read-out");
  AST_ONE_RD: assert property (rd_out_r |->
                               !(tx_push && tx_win[`DTA_E_ST] && tx_win[`DTA_H0_FT] == `DTA_FT_MRD))
    else $error("second read issued while one outstanding");
  AST_OTHER_CH: assert property (bus_go && wb_chan > `DTA_CH_RD &&
                                 bs_r == dta_pkg::DTA_B_IDLE |-> !tx_push)
    else $error("unused channel produced a tlp");
  AST_WR_LEN: assert property (bs_r == dta_pkg::DTA_B_IDLE && is_wr && tx_space |->
                               tx_push && {tx_win[`DTA_H0_LEN], 2'h0} == 12'(wb_blen))
    else $error("write tlp length does not match burst length");
endmodule

//--- test/dta_core_model.sv
// pcie core transmit side: grants each request once, takes words, may stall
// assumes the adapter's tx handshake on clk_sys; slow paces grant and accept
`timescale 1ns/1ps
module dta_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // transmit from the adapter
  input wire logic tx_req,
  input wire logic tx_val,
  input wire logic [63:0] tx_data,
  output logic tx_rdy,
  output logic tx_accept,
  // pacing
  input wire logic slow
);
  logic [63:0] words[$];
  logic [3:0] cnt_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_rdy <= 1'b0;
      tx_accept <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      // a single grant pulse, so a late falling request is not granted twice
      tx_rdy <= tx_req && !tx_rdy && (!slow || cnt_r[1:0] == 2'h3);
      tx_accept <= !slow || cnt_r[0];
      if (tx_val && tx_accept) begin
        words.push_back(tx_data);
      end
    end
  end
endmodule

//--- test/test_dma_to_pcie_tlp_adapter.sv
// bench of dta_top: drives the dma master side, models the core, checks every result
// assumes dta_top and dta_core_model are compiled first
`timescale 1ns/1ps
module test_dma_to_pcie_tlp_adapter;
  localparam int NCH = 5;
  logic clk_sys = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [2:0] wb_chan = 3'h0;
  logic [31:0] wb_adr = 32'h0, a;
  logic [7:0] wb_blen = 8'h08, tx_ca_ph = 8'h10, tx_ca_nph = 8'h10, bl[3];
  logic [11:0] tx_ca_pd = 12'h020;
  logic [63:0] wb_wdata = 64'h0, rx_data = 64'h0, wb_rdata, tx_data, h, rq[$], rexp[$];
  logic wb_ack, wb_rty, tx_req, tx_rdy, tx_val, tx_st, tx_end, tx_accept, rx_cr_cplh, rx_cr_cpld;
  logic rx_val = 1'b0, rx_st = 1'b0, rx_end = 1'b0, slow = 1'b0, grant = 1'b0, run = 1'b0;
  logic [NCH-1:0] dma_req;
  int err_count = 0, compares = 0, acks, rty, ncpld = 0, ncplh = 0, early = 0, badreq = 0, c;
  int wpos = 0, framing = 0, ntlp = 0;

  dta_top #(.NCH(NCH)) uut (.clk_sys, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_chan, .wb_adr,
    .wb_blen, .wb_wdata, .wb_ack, .wb_rty, .wb_rdata, .dma_req, .tx_req, .tx_rdy, .tx_val,
    .tx_st, .tx_end, .tx_data, .tx_accept, .tx_ca_ph, .tx_ca_pd, .tx_ca_nph, .rx_val, .rx_st,
    .rx_end, .rx_data, .rx_cr_cplh, .rx_cr_cpld);
  dta_core_model core (.clk_sys, .rst_n, .tx_req, .tx_val, .tx_data, .tx_rdy, .tx_accept,
    .slow);

  always #10 clk_sys = ~clk_sys;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [63:0] dat(input logic [31:0] ad, input int k);
    return {ad, 32'(k)} ^ 64'h5a5a_0000_a5a5_0000;
  endfunction

  // one master cycle, held until all beats are acked, a retry, or lim edges
  task automatic bus(input logic we, input logic [2:0] ch, input logic [31:0] ad,
                     input logic [7:0] blen, input int lim);
    int w;
    w = 0;
    acks = 0;
    rty = 0;
    rq = {};
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_chan <= ch;
    wb_adr <= ad;
    wb_blen <= blen;
    wb_wdata <= dat(ad, 0);
    while (acks < blen / 8 && rty == 0 && w < lim) begin
      @(posedge clk_sys);
      w++;
      if (wb_ack === 1'b1) begin
        rq.push_back(wb_rdata);
        acks++;
        wb_wdata <= dat(ad, acks);
      end
      if (wb_rty === 1'b1) rty = 1;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  // waits for the next tlp at the core and compares header and data
  task automatic tlp(input logic [7:0] ft, input logic [31:0] ad, input int dw, input int nd);
    int w;
    w = 0;
    while (core.words.size() < 2 + nd && w < 400) begin
      @(posedge clk_sys);
      w++;
    end
    chk(core.words.size() >= 2 + nd, 1'b1);
    if (core.words.size() < 2 + nd) return;
    h = core.words.pop_front();
    chk({h[63:56], h[41:32], h[7:0]}, {ft, 10'(dw), 8'hff});
    chk(core.words.pop_front(), {32'h0, ad});
    for (w = 0; w < nd; w++) chk(core.words.pop_front(), dat(ad, w));
  endtask

  task automatic cpl(input logic [7:0] tag, input int n, input logic keep);
    int k;
    logic [63:0] d;
    for (k = 0; k < n + 2; k++) begin
      d = {$urandom, $urandom};
      if (k == 0) d = {8'h4a, 14'h0, 10'(2 * n), 16'h0, tag, 8'hff};
      if (k == 1) d = {32'h0, tag, 24'h0};
      if (k > 1 && keep) rexp.push_back(d);
      @(posedge clk_sys);
      rx_val <= 1'b1;
      rx_st <= (k == 0);
      rx_end <= (k == n + 1);
      rx_data <= d;
    end
    @(posedge clk_sys);
    rx_val <= 1'b0;
    rx_st <= 1'b0;
    rx_end <= 1'b0;
    rx_data <= ~d;
  endtask

  always @(posedge clk_sys) begin
    if (run && rst_n) begin
      ncpld += int'(rx_cr_cpld === 1'b1);
      ncplh += int'(rx_cr_cplh === 1'b1);
      if (tx_rdy === 1'b1) grant = 1'b1;
      if (tx_val === 1'b1 && !grant) early++;
      // every accepted word: start mark only on the first word of a tlp
      if (tx_val === 1'b1 && tx_accept === 1'b1) begin
        if (tx_st !== (wpos == 0)) framing++;
        ntlp += int'(tx_end === 1'b1);
        wpos = (tx_end === 1'b1) ? 0 : wpos + 1;
      end
      if (tx_val === 1'b1 && tx_accept === 1'b1 && tx_end === 1'b1) grant = 1'b0;
      if (dma_req[0] !== 1'b0 || dma_req[NCH-1:2] !== '0) badreq++;
    end
  end

  initial begin
    #(20 * 20000);
    err_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'h6610972a));
    bl = '{8'h08, 8'h80, 8'($urandom_range(16, 1) * 8)};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    run = 1'b1;
    // shortest, longest and a random burst; the core stalls on the last
    foreach (bl[i]) begin
      a = $urandom & 32'hffff_fff8;
      slow <= (i == 2);
      bus(1'b1, 3'h0, a, bl[i], 300);
      chk(acks, bl[i] / 8);
      tlp(8'h40, a, bl[i] / 4, bl[i] / 8);
    end
    tx_ca_ph <= 8'h00;
    bus(1'b1, 3'h0, a, 8'h80, 300);
    repeat (30) @(posedge clk_sys);
    chk(tx_req, 1'b0);
    tx_ca_ph <= 8'h01;
    tx_ca_pd <= 12'h007;
    repeat (30) @(posedge clk_sys);
    chk(core.words.size(), 0);
    tx_ca_pd <= 12'h008;
    tlp(8'h40, a, 32, 16);
    for (c = 2; c < 8; c++) begin
      bus(c[0], 3'(c), a, 8'h08, 12);
      chk(acks + rty, 0);
    end
    chk(core.words.size(), 0);
    tx_ca_nph <= 8'h00;
    bus(1'b0, 3'h1, a, 8'h20, 4);
    chk(rty, 1);
    repeat (30) @(posedge clk_sys);
    chk(core.words.size(), 0);
    bus(1'b0, 3'h1, a, 8'h20, 4);
    chk(rty, 1);
    tx_ca_nph <= 8'h01;
    tlp(8'h00, a, 8, 0);
    chk(h[15:8], 8'h00);
    repeat (20) @(posedge clk_sys);
    chk(core.words.size(), 0);
    cpl(8'h07, 4, 1'b0);
    cpl(8'h00, 2, 1'b1);
    repeat (5) @(posedge clk_sys);
    chk(dma_req, 64'h0);
    cpl(8'h00, 2, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk(dma_req, 64'h2);
    chk(ncpld + ncplh, 0);
    bus(1'b0, 3'h1, a, 8'h20, 100);
    chk(acks, 4);
    foreach (rq[i]) chk(rq[i], rexp[i]);
    repeat (3) @(posedge clk_sys);
    chk({ncpld, ncplh}, {32'd4, 32'd1});
    chk(dma_req, 64'h0);
    bus(1'b0, 3'h1, a, 8'h08, 4);
    tlp(8'h00, a, 2, 0);
    chk(h[15:8], 8'h01);
    // reset with a read outstanding: a new read must go out again with tag 0
    rst_n <= 1'b0;
    @(posedge clk_sys);
    chk({tx_req, dma_req}, 64'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, 3'h1, a, 8'h08, 4);
    tlp(8'h00, a, 2, 0);
    chk(h[15:8], 8'h00);
    chk({early, badreq}, 64'h0);
    chk({framing, ntlp}, {32'd0, 32'd7});
    final_report();
  end
endmodule
